// ==== pkg/load16_pkg.sv ====
package load16_pkg;
    typedef enum logic [3:0] {
        ST_FETCH = 4'b0000,
        ST_OPCODE = 4'b0001,
        ST_OPER_HI = 4'b0010,
        ST_OPER_LO = 4'b0011,
        ST_DUMMY = 4'b0100,
        ST_DATA_HI = 4'b0101,
        ST_DATA_LO = 4'b0110
    } phase_t;
    typedef enum logic [1:0] {
        DST_D = 2'b00,
        DST_S = 2'b01,
        DST_X = 2'b10,
        DST_Y = 2'b11
    } dest_t;
    typedef enum logic [2:0] {
        MODE_IMM = 3'b000,
        MODE_DIR = 3'b001,
        MODE_EXT = 3'b010,
        MODE_INDX = 3'b011,
        MODE_INDY = 3'b100
    } mode_t;
    typedef struct packed {
        logic [15:0] addr;
        logic read;
    } bus_t;
    typedef struct packed {
        logic [7:0] accumulator_a;
        logic [7:0] accumulator_b;
        logic [15:0] stack_pointer;
        logic [15:0] first_index;
        logic [15:0] second_index;
        logic [7:0] ccr;
    } regs_t;
    typedef struct packed {
        phase_t phase;
        logic [1:0] page;
        dest_t dest;
        mode_t mode;
        logic [15:0] pc;
        logic [15:0] ea;
        logic [7:0] hi;
        regs_t regs;
        bus_t bus;
        logic done;
        logic illegal;
    } state_t;
endpackage : load16_pkg

// ==== pkg/load16_regs.svh ====
`ifndef LOAD16_REGS_SVH
`define LOAD16_REGS_SVH
// Opcode and prefix bytes
`define OPC_PREFIX_SECOND 8'h18
`define OPC_PREFIX_FIRST_ON_SECOND 8'h1a
`define OPC_PREFIX_SECOND_ON_FIRST 8'hcd
`define OPC_D_IMM 8'hcc
`define OPC_D_DIR 8'hdc
`define OPC_D_IND 8'hec
`define OPC_D_EXT 8'hfc
`define OPC_S_IMM 8'h8e
`define OPC_S_DIR 8'h9e
`define OPC_S_IND 8'hae
`define OPC_S_EXT 8'hbe
`define OPC_X_IMM 8'hce
`define OPC_X_DIR 8'hde
`define OPC_X_IND 8'hee
`define OPC_X_EXT 8'hfe
// Dummy cycle address of indexed forms
`define DUMMY_ADDR 16'hffff
// Reset values
`define RESET_PC 16'h0000
`define RESET_WORD 16'h0000
`define RESET_CCR 8'h00
// Condition code bit positions
`define CCR_N 3
`define CCR_Z 2
`define CCR_V 1
`endif

// ==== rtl/sixteen_bit_load_execution.sv ====
`timescale 1ns/10ps
`include "load16_regs.svh"
// What this block does
// (RULE_01) Double-accumulator opcodes, modes and cycle counts
// (RULE_02) Stack-pointer opcodes, same cycle counts
// (RULE_03) First-index opcodes, CD prefix for second-indexed
// (RULE_04) Second-index opcodes under 18 and 1A
// (RULE_05) Stack pointer: high from EA, low EA+1
// (RULE_06) First index: high then low, consecutive reads
// (RULE_07) Second index bytes; indexed forms dummy-read FFFF
// (RULE_08) N from bit 15, Z on zero, V cleared
// (RULE_09) Accumulator A from EA, B from EA+1
// (RULE_10) Indexed EA: index plus unsigned offset byte
module sixteen_bit_load_execution (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic NRST,
    // Memory bus, one read per cycle
    output load16_pkg::bus_t BUS,
    input wire logic [7:0] RDATA,
    // Programmer state
    output load16_pkg::regs_t REGS,
    // Status
    output logic DONE,
    output logic ILLEGAL
);
    import load16_pkg::*;

    state_t s;
    state_t next_s;
    logic [7:0] op;
    logic [15:0] word;
    logic [15:0] index;
    logic [15:0] word_last;

    assign BUS = s.bus;
    assign REGS = s.regs;
    assign DONE = s.done;
    assign ILLEGAL = s.illegal;
    assign op = RDATA;
    assign word = {s.hi, RDATA};
    assign index = (s.mode == MODE_INDY) ? s.regs.second_index
                                          : s.regs.first_index;

    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        next_s.illegal = 1'b0;
        next_s.bus.read = 1'b1;
        unique case (s.phase)
            ST_FETCH: begin
                // Bus shows the opcode (or prefix) address this cycle
                next_s.page = 2'd0;
                next_s.pc = s.pc + 16'h0001;
                next_s.bus.addr = s.pc + 16'h0001;
                next_s.phase = ST_OPCODE;
                if (op == `OPC_PREFIX_SECOND) begin
                    next_s.page = 2'd1; // RULE_04
                end else if (op == `OPC_PREFIX_FIRST_ON_SECOND) begin
                    next_s.page = 2'd2; // RULE_04
                end else if (op == `OPC_PREFIX_SECOND_ON_FIRST) begin
                    next_s.page = 2'd3; // RULE_03
                end else begin
                    next_s.phase = ST_OPCODE;
                    next_s.page = 2'd0;
                end
                if (op != `OPC_PREFIX_SECOND
                    && op != `OPC_PREFIX_FIRST_ON_SECOND
                    && op != `OPC_PREFIX_SECOND_ON_FIRST) begin
                    // Unprefixed opcode: decode now, same cycle
                    next_s.phase = ST_OPER_HI;
                    next_s.mode = MODE_IMM;
                    next_s.dest = DST_D;
                    unique case (op)
                        `OPC_D_IMM: next_s.mode = MODE_IMM; // RULE_01
                        `OPC_D_DIR: next_s.mode = MODE_DIR; // RULE_01
                        `OPC_D_EXT: next_s.mode = MODE_EXT; // RULE_01
                        `OPC_D_IND: next_s.mode = MODE_INDX; // RULE_01
                        `OPC_S_IMM, `OPC_S_DIR, `OPC_S_EXT,
                        `OPC_S_IND: next_s.dest = DST_S; // RULE_02
                        `OPC_X_IMM, `OPC_X_DIR, `OPC_X_EXT,
                        `OPC_X_IND: next_s.dest = DST_X; // RULE_03
                        default: begin
                            next_s.phase = ST_FETCH;
                            next_s.illegal = 1'b1;
                        end
                    endcase
                    if (op[5:4] == 2'b01) next_s.mode = MODE_DIR;
                    if (op[5:4] == 2'b11) next_s.mode = MODE_EXT;
                    if (op[5:4] == 2'b10) next_s.mode = MODE_INDX;
                    if (op[5:4] == 2'b00) next_s.mode = MODE_IMM;
                end
            end
            ST_OPCODE: begin
                // Second byte after a prefix
                next_s.pc = s.pc + 16'h0001;
                next_s.bus.addr = s.pc + 16'h0001;
                next_s.phase = ST_OPER_HI;
                next_s.mode = MODE_INDY;
                next_s.dest = DST_Y;
                if (s.page == 2'd1 && op == `OPC_D_IND) begin
                    next_s.dest = DST_D; // RULE_01
                end else if (s.page == 2'd1 && op == `OPC_S_IND) begin
                    next_s.dest = DST_S; // RULE_02
                end else if (s.page == 2'd1 && op == `OPC_X_IMM) begin
                    next_s.mode = MODE_IMM; // RULE_04
                end else if (s.page == 2'd1 && op == `OPC_X_DIR) begin
                    next_s.mode = MODE_DIR; // RULE_04
                end else if (s.page == 2'd1 && op == `OPC_X_EXT) begin
                    next_s.mode = MODE_EXT; // RULE_04
                end else if (s.page == 2'd1 && op == `OPC_X_IND) begin
                    next_s.mode = MODE_INDY; // RULE_04
                end else if (s.page == 2'd2 && op == `OPC_X_IND) begin
                    next_s.mode = MODE_INDX; // RULE_04
                end else if (s.page == 2'd3 && op == `OPC_X_IND) begin
                    next_s.dest = DST_X; // RULE_03
                end else begin
                    next_s.phase = ST_FETCH;
                    next_s.illegal = 1'b1;
                end
            end
            ST_OPER_HI: begin
                // First operand byte: jj, dd, hh or ff
                next_s.pc = s.pc + 16'h0001;
                next_s.hi = RDATA;
                unique case (s.mode)
                    MODE_IMM: begin
                        next_s.bus.addr = s.pc + 16'h0001;
                        next_s.phase = ST_DATA_LO;
                        next_s.ea = s.pc;
                    end
                    MODE_DIR: begin
                        // One operand byte: the last data step moves past it
                        next_s.pc = s.pc;
                        next_s.ea = {8'h00, RDATA};
                        next_s.bus.addr = {8'h00, RDATA}; // RULE_01
                        next_s.phase = ST_DATA_HI;
                    end
                    MODE_EXT: begin
                        next_s.bus.addr = s.pc + 16'h0001;
                        next_s.phase = ST_OPER_LO;
                    end
                    default: begin
                        // Adder runs in this cycle, with the offset read; the dummy cycle only reads FFFF
                        next_s.ea = index + {8'h00, RDATA}; // RULE_10
                        next_s.bus.addr = `DUMMY_ADDR; // RULE_07
                        next_s.phase = ST_DUMMY;
                        next_s.pc = s.pc;
                    end
                endcase
            end
            ST_OPER_LO: begin
                next_s.ea = word;
                next_s.bus.addr = word;
                next_s.phase = ST_DATA_HI;
            end
            ST_DUMMY: begin
                next_s.bus.addr = s.ea;
                next_s.phase = ST_DATA_HI;
            end
            ST_DATA_HI: begin
                next_s.hi = RDATA;
                next_s.bus.addr = s.ea + 16'h0001; // RULE_06
                next_s.phase = ST_DATA_LO;
            end
            ST_DATA_LO: begin
                next_s.phase = ST_FETCH;
                next_s.bus.addr = s.pc + 16'h0001;
                next_s.pc = s.pc + 16'h0001;
                next_s.done = 1'b1;
                unique case (s.dest)
                    DST_D: begin
                        next_s.regs.accumulator_a = s.hi; // RULE_09
                        next_s.regs.accumulator_b = RDATA; // RULE_09
                    end
                    DST_S: next_s.regs.stack_pointer = word; // RULE_05
                    DST_X: next_s.regs.first_index = word; // RULE_06
                    DST_Y: next_s.regs.second_index = word; // RULE_07
                endcase
                next_s.regs.ccr[`CCR_N] = word[15]; // RULE_08
                next_s.regs.ccr[`CCR_Z] = (word == 16'h0000); // RULE_08
                next_s.regs.ccr[`CCR_V] = 1'b0; // RULE_08
            end
            default: begin
                next_s.phase = ST_FETCH;
            end
        endcase
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            s <= '0;
            // Strobe high out of reset so the first fetch is a real read
            s.bus.read <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // Direct form reads 00dd then 00dd+1 on the next two cycles
    sequence dir_reads_s;
        (s.phase == ST_DATA_HI) ##1 (s.phase == ST_DATA_LO);
    endsequence
    flag_update_a: assert property (@(posedge CLOCK) disable iff (!NRST) // RULE_08
        s.done |-> (s.regs.ccr[`CCR_V] == 1'b0)
            && (s.regs.ccr[`CCR_Z] == (word_last == 16'h0000)))
        else $error("condition codes wrong after load");
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) word_last <= 16'h0000;
        else if (s.phase == ST_DATA_LO) word_last <= word;
    end
    neg_flag_a: assert property (@(posedge CLOCK) disable iff (!NRST) // RULE_08
        s.done |-> s.regs.ccr[`CCR_N] == word_last[15])
        else $error("negative flag not from bit 15");
    dummy_read_a: assert property (@(posedge CLOCK) disable iff (!NRST) // RULE_07
        s.phase == ST_DUMMY |-> BUS.addr == 16'hffff && BUS.read)
        else $error("dummy cycle not at ffff");
    ea_plus_one_a: assert property (@(posedge CLOCK) disable iff (!NRST) // RULE_06
        s.phase == ST_DATA_HI |=> BUS.addr == $past(BUS.addr) + 16'h0001)
        else $error("second data read not at next address");
    data_pair_a: assert property (@(posedge CLOCK) disable iff (!NRST) // RULE_05
        s.phase == ST_DATA_HI |-> ##1 (s.phase == ST_DATA_LO) ##1 s.done)
        else $error("data reads not consecutive");
    dir_page_a: assert property (@(posedge CLOCK) disable iff (!NRST) // RULE_01
        (s.phase == ST_DATA_HI && s.mode == MODE_DIR)
            |-> BUS.addr[15:8] == 8'h00)
        else $error("direct read outside page zero");
    dir_seq_a: assert property (@(posedge CLOCK) disable iff (!NRST) // RULE_01
        (s.phase == ST_OPER_HI && s.mode == MODE_DIR) |=> dir_reads_s)
        else $error("direct sequence broken");
    acc_load_a: assert property (@(posedge CLOCK) disable iff (!NRST) // RULE_09
        (s.phase == ST_DATA_LO && s.dest == DST_D)
            |=> REGS.accumulator_a == $past(s.hi)
                && REGS.accumulator_b == $past(RDATA))
        else $error("accumulator bytes swapped");
    indexed_ea_a: assert property (@(posedge CLOCK) disable iff (!NRST) // RULE_10
        (s.phase == ST_OPER_HI && s.mode == MODE_INDX)
            |=> s.ea == $past(s.regs.first_index) + {8'h00, $past(RDATA)})
        else $error("indexed address wrong");
    done_excl_a: assert property (@(posedge CLOCK) disable iff (!NRST)
        !(s.done && s.illegal))
        else $error("done and illegal together");
endmodule : sixteen_bit_load_execution

// ==== tb/load16_memory.sv ====
`timescale 1ns/10ps
module load16_memory (
    // Clock and bus from the block
    input wire logic clock,
    input wire load16_pkg::bus_t bus,
    // Byte returned in the same cycle
    output logic [7:0] rdata
);
    import load16_pkg::*;
    logic [7:0] mem [0:65535];
    logic [7:0] last = 8'h00;
    // Without a read strobe the bus shows a changing byte, never stale data
    assign rdata = bus.read ? mem[bus.addr] : ~last;
    always @(posedge clock) last <= rdata;
endmodule : load16_memory

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
`include "load16_regs.svh"
module tb_top;
    import load16_pkg::*;
    localparam logic [7:0] NP = 8'h00;
    localparam logic [7:0] P18 = `OPC_PREFIX_SECOND;
    logic CLOCK = 1'b0;
    logic NRST = 1'b0;
    bus_t BUS;
    logic [7:0] RDATA;
    regs_t REGS;
    logic DONE;
    logic ILLEGAL;
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    int pc = 0;
    int gap;
    int exp_gap;
    bit rd_low;
    int ill = 0;
    bit seen;
    regs_t model;
    regs_t exp_q [$];
    int cyc_q [$];
    bit ind_q [$];
    always #2.5 CLOCK = ~CLOCK;
    sixteen_bit_load_execution uut (
        .CLOCK(CLOCK), .NRST(NRST), .BUS(BUS), .RDATA(RDATA),
        .REGS(REGS), .DONE(DONE), .ILLEGAL(ILLEGAL));
    load16_memory mem_i (.clock(CLOCK), .bus(BUS), .rdata(RDATA));
    task automatic end_sim;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim
    task automatic check(input bit ok, input string msg);
        num_checks++;
        if (!ok) begin
            num_errors++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask : check
    task automatic put(input logic [7:0] b);
        mem_i.mem[pc] = b;
        pc++;
    endtask : put
    // Lays one load into memory and works out the state it must leave
    task automatic ins(input logic [7:0] pre, input logic [7:0] op,
                       input mode_t md, input dest_t dst,
                       input logic [15:0] opnd, input logic [15:0] val,
                       input int cyc);
        logic [15:0] ea;
        if (pre != NP) put(pre);
        put(op);
        if (md == MODE_IMM || md == MODE_EXT) put(opnd[15:8]);
        put(opnd[7:0]);
        case (md)
            MODE_DIR: ea = {8'h00, opnd[7:0]};
            MODE_EXT: ea = opnd;
            MODE_INDX: ea = model.first_index + {8'h00, opnd[7:0]};
            MODE_INDY: ea = model.second_index + {8'h00, opnd[7:0]};
            default: ea = 16'h0000;
        endcase
        if (md != MODE_IMM) begin
            mem_i.mem[ea] = val[15:8];
            mem_i.mem[ea + 16'h0001] = val[7:0];
        end
        case (dst)
            DST_D: {model.accumulator_a, model.accumulator_b} = val;
            DST_S: model.stack_pointer = val;
            DST_X: model.first_index = val;
            default: model.second_index = val;
        endcase
        model.ccr[`CCR_N] = val[15];
        model.ccr[`CCR_Z] = (val == 16'h0000);
        model.ccr[`CCR_V] = 1'b0;
        exp_q.push_back(model);
        cyc_q.push_back(cyc);
        ind_q.push_back(md == MODE_INDX || md == MODE_INDY);
    endtask : ins
    always @(posedge CLOCK) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            $display("ERROR %0t timeout", $time);
            end_sim();
        end
    end
    initial begin
        for (int a = 0; a < 65536; a++) mem_i.mem[a] = 8'h01;
        model = '0;
        put(8'h01);
        ins(NP, `OPC_X_IMM, MODE_IMM, DST_X, 16'h40f0, 16'h40f0, 3);
        ins(P18, `OPC_X_IMM, MODE_IMM, DST_Y, 16'h41e8, 16'h41e8, 4);
        ins(NP, `OPC_D_IMM, MODE_IMM, DST_D, 16'h8000, 16'h8000, 3);
        ins(NP, `OPC_S_IMM, MODE_IMM, DST_S, 16'h0000, 16'h0000, 3);
        ins(NP, `OPC_D_DIR, MODE_DIR, DST_D, 16'h00c0, 16'h1234, 4);
        ins(NP, `OPC_S_DIR, MODE_DIR, DST_S, 16'h00c2, 16'hfedc, 4);
        ins(NP, `OPC_D_EXT, MODE_EXT, DST_D, 16'h4000, 16'h00ff, 5);
        ins(NP, `OPC_S_EXT, MODE_EXT, DST_S, 16'h4002, 16'h7f00, 5);
        ins(NP, `OPC_D_IND, MODE_INDX, DST_D, 16'h0020, 16'ha55a, 5);
        ins(NP, `OPC_S_IND, MODE_INDX, DST_S, 16'h0030, 16'h0001, 5);
        ins(P18, `OPC_D_IND, MODE_INDY, DST_D, 16'h0040, 16'h8001, 6);
        ins(P18, `OPC_S_IND, MODE_INDY, DST_S, 16'h0050, 16'h0000, 6);
        ins(`OPC_PREFIX_FIRST_ON_SECOND, `OPC_X_IND, MODE_INDX, DST_Y,
            16'h0060, 16'h5000, 6);
        ins(P18, `OPC_X_IND, MODE_INDY, DST_Y, 16'h0070, 16'h6000, 6);
        ins(P18, `OPC_X_DIR, MODE_DIR, DST_Y, 16'h00c4, 16'h9999, 5);
        ins(`OPC_PREFIX_SECOND_ON_FIRST, `OPC_X_IND, MODE_INDY, DST_X,
            16'h0080, 16'h4321, 6);
        ins(P18, `OPC_X_EXT, MODE_EXT, DST_Y, 16'h4004, 16'h0000, 6);
        ins(NP, `OPC_X_DIR, MODE_DIR, DST_X, 16'h00c6, 16'h0000, 4);
        ins(NP, `OPC_X_EXT, MODE_EXT, DST_X, 16'h4006, 16'h8888, 5);
        ins(NP, `OPC_X_IND, MODE_INDX, DST_X, 16'h0090, 16'h7777, 5);
        repeat (4) @(posedge CLOCK);
        #1 NRST = 1'b1;
        foreach (exp_q[i]) begin
            gap = 0;
            seen = 1'b0;
            rd_low = 1'b0;
            // The skipped byte ahead of the first load costs one cycle
            exp_gap = cyc_q[i] + (i == 0);
            do begin
                @(posedge CLOCK);
                #1 gap++;
                if (BUS.addr === `DUMMY_ADDR) seen = 1'b1;
                if (BUS.read !== 1'b1) rd_low = 1'b1;
                if (ILLEGAL === 1'b1) ill++;
            end while (DONE !== 1'b1 && gap < 20);
            check(REGS === exp_q[i], "state");
            check(REGS.ccr === exp_q[i].ccr, "flags");
            check(gap == exp_gap, "cyc");
            check(seen == ind_q[i], "dummy read");
            check(!rd_low, "read strobe low");
            $display("test %0d done", i);
        end
        check(ill == 1, "unknown opcode skipped");
        end_sim();
    end
endmodule : tb_top
